// >>> fwekg_guard.v
/*
  Flash write/erase key guard. Holds the program-store control register
  and the lock-and-key state machine, and turns external-data writes into
  flash byte programs, page erases, ordinary data writes or blocked tries.
  Assumes one 200 MHz clock, a synchronous active-low reset, a register
  port with one-cycle strobes, and a flash back end that raises a done
  pulse once per started operation.
*/
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fwekg_defs.vh"

module fwekg_guard #(
  parameter ADDR_W = 16
) (
  input wire i_clk,
  input wire i_rst_n,
  // Register port
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output wire [7:0] o_reg_rdata,
  // External-data write request from the core
  input wire i_xw_req,
  input wire [ADDR_W-1:0] i_xw_addr,
  input wire [7:0] i_xw_data,
  // Ordinary data memory write
  output reg o_dm_wr,
  output reg [ADDR_W-1:0] o_dm_addr,
  output reg [7:0] o_dm_data,
  // Flash back end, then busy, trap and interrupt outputs
  output reg o_fl_prog,
  output reg o_fl_erase,
  output reg [ADDR_W-1:0] o_fl_addr,
  output reg [7:0] o_fl_data,
  input wire i_fl_done,
  output wire o_fl_busy,
  output wire o_trapped,
  output wire o_irq
);

  reg [1:0] psc_ff;
  reg [1:0] lock_ff;
  reg busy_ff;
  reg [`FWEKG_IRQ_W-1:0] stat_ff;
  reg [`FWEKG_IRQ_W-1:0] en_ff;
  reg [1:0] nxt_lock;
  reg [`FWEKG_IRQ_W-1:0] nxt_stat;

  wire we_bit = psc_ff[`FWEKG_BIT_WE];
  wire ee_bit = psc_ff[`FWEKG_BIT_EE];
  wire key_wr = i_reg_wr && (i_reg_addr == `FWEKG_ADDR_KEY);
  // Flash-targeted write: only while write enable is set
  wire fl_try = i_xw_req && we_bit;
  wire fl_ok = fl_try && (lock_ff == `FWEKG_ST_OPEN) && !busy_ff;
  wire fl_bad = fl_try && !fl_ok;
  wire op_done = busy_ff && i_fl_done;

  // Control register; only the two enable bits are stored
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      psc_ff <= `FWEKG_PSC_RST;
    end else if (i_reg_wr && (i_reg_addr == `FWEKG_ADDR_PSC)) begin
      psc_ff <= i_reg_wdata[1:0];
    end
  end

  // Lock-and-key state machine
  always @* begin
    nxt_lock = lock_ff;
    case (lock_ff)
      `FWEKG_ST_LOCKED: begin
        if (fl_bad) begin
          nxt_lock = `FWEKG_ST_DEAD;
        end else if (key_wr) begin
          if (i_reg_wdata == `FWEKG_KEY1) begin
            nxt_lock = `FWEKG_ST_KEY1;
          end else begin
            nxt_lock = `FWEKG_ST_DEAD;
          end
        end
      end
      `FWEKG_ST_KEY1: begin
        if (fl_bad) begin
          nxt_lock = `FWEKG_ST_DEAD;
        end else if (key_wr) begin
          if (i_reg_wdata == `FWEKG_KEY2) begin
            nxt_lock = `FWEKG_ST_OPEN;
          end else begin
            nxt_lock = `FWEKG_ST_DEAD;
          end
        end
      end
      `FWEKG_ST_OPEN: begin
        if (fl_bad || key_wr) begin
          nxt_lock = `FWEKG_ST_DEAD;
        end else if (op_done) begin
          nxt_lock = `FWEKG_ST_LOCKED;
        end
      end
      `FWEKG_ST_DEAD: nxt_lock = `FWEKG_ST_DEAD;
      default: nxt_lock = `FWEKG_ST_DEAD;
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      lock_ff <= `FWEKG_ST_LOCKED;
    end else begin
      lock_ff <= nxt_lock;
    end
  end

  // Busy from start of a flash operation until the back end reports done
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      busy_ff <= 1'b0;
    end else if (fl_ok) begin
      busy_ff <= 1'b1;
    end else if (i_fl_done) begin
      busy_ff <= 1'b0;
    end
  end

  // Route each write: flash program, page erase, data memory or nothing
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_fl_prog <= 1'b0;
      o_fl_erase <= 1'b0;
      o_fl_addr <= {ADDR_W{1'b0}};
      o_fl_data <= 8'h00;
      o_dm_wr <= 1'b0;
      o_dm_addr <= {ADDR_W{1'b0}};
      o_dm_data <= 8'h00;
    end else begin
      o_fl_prog <= fl_ok && !ee_bit;
      o_fl_erase <= fl_ok && ee_bit;
      o_dm_wr <= i_xw_req && !we_bit;
      if (fl_ok) begin
        o_fl_addr <= i_xw_addr;
        // Erase drops the data byte
        o_fl_data <= ee_bit ? 8'h00 : i_xw_data;
      end
      if (i_xw_req && !we_bit) begin
        o_dm_addr <= i_xw_addr;
        o_dm_data <= i_xw_data;
      end
    end
  end

  // Sticky interrupt status; a new event wins over a clear
  always @* begin
    nxt_stat = stat_ff;
    if (i_reg_wr && (i_reg_addr == `FWEKG_ADDR_IRQ_CLR)) begin
      nxt_stat = stat_ff & ~i_reg_wdata[`FWEKG_IRQ_W-1:0];
    end
    if (op_done) begin
      nxt_stat[`FWEKG_IRQ_DONE] = 1'b1;
    end
    if ((nxt_lock == `FWEKG_ST_DEAD) && (lock_ff != `FWEKG_ST_DEAD)) begin
      nxt_stat[`FWEKG_IRQ_TRAP] = 1'b1;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      stat_ff <= {`FWEKG_IRQ_W{1'b0}};
      en_ff <= {`FWEKG_IRQ_W{1'b0}};
    end else begin
      stat_ff <= nxt_stat;
      if (i_reg_wr && (i_reg_addr == `FWEKG_ADDR_IRQ_EN)) begin
        en_ff <= i_reg_wdata[`FWEKG_IRQ_W-1:0];
      end
    end
  end

  assign o_irq = |(stat_ff & en_ff);
  assign o_fl_busy = busy_ff;
  assign o_trapped = (lock_ff == `FWEKG_ST_DEAD);

  // Read-back register
  fwekg_reg_mux u_mux (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_rd(i_reg_rd),
    .i_addr(i_reg_addr),
    .i_psc(psc_ff),
    .i_lock(lock_ff),
    .i_stat(stat_ff),
    .i_en(en_ff),
    .o_rdata(o_reg_rdata)
  );

endmodule
`default_nettype wire

// >>> fwekg_defs.vh
/*
  Constants for the flash write/erase key guard: register offsets, field
  positions, key values, lock state codes and reset values.
  Assumes it is included by its bare name from the design files.
*/
`ifndef FWEKG_DEFS_VH
`define FWEKG_DEFS_VH

// Register offsets on the plain register port
`define FWEKG_ADDR_PSC 8'h8f
`define FWEKG_ADDR_KEY 8'hb7
`define FWEKG_ADDR_IRQ_STAT 8'hc0
`define FWEKG_ADDR_IRQ_EN 8'hc1
`define FWEKG_ADDR_IRQ_CLR 8'hc2

// Control register fields and reset value
`define FWEKG_BIT_WE 0
`define FWEKG_BIT_EE 1
`define FWEKG_PSC_RST 2'b00

// Key values
`define FWEKG_KEY1 8'ha5
`define FWEKG_KEY2 8'hf1

// Lock state codes
`define FWEKG_ST_LOCKED 2'b00
`define FWEKG_ST_KEY1 2'b01
`define FWEKG_ST_OPEN 2'b10
`define FWEKG_ST_DEAD 2'b11

// Interrupt status bits
`define FWEKG_IRQ_DONE 0
`define FWEKG_IRQ_TRAP 1
`define FWEKG_IRQ_W 2

`endif

// >>> fwekg_reg_mux.v
/*
  Read-data register for the key guard: selects one of the readable
  registers by address and holds it for the cycle after the read strobe.
  Assumes the caller presents the register values on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fwekg_defs.vh"

module fwekg_reg_mux (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_rd,
  input wire [7:0] i_addr,
  input wire [1:0] i_psc,
  input wire [1:0] i_lock,
  input wire [`FWEKG_IRQ_W-1:0] i_stat,
  input wire [`FWEKG_IRQ_W-1:0] i_en,
  output reg [7:0] o_rdata
);

  reg [7:0] nxt_rdata;

  // Address decode; unmapped and write-only offsets read as zero
  always @* begin
    nxt_rdata = 8'h00;
    case (i_addr)
      `FWEKG_ADDR_PSC: nxt_rdata = {6'h00, i_psc};
      `FWEKG_ADDR_KEY: nxt_rdata = {6'h00, i_lock};
      `FWEKG_ADDR_IRQ_STAT: nxt_rdata = {6'h00, i_stat};
      `FWEKG_ADDR_IRQ_EN: nxt_rdata = {6'h00, i_en};
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= nxt_rdata;
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// >>> fwekg_checker.sv
/* Port assertions for the flash key guard.
   Assumes it is bound into fwekg_guard. */
`timescale 1ns/1ps
`default_nettype none
`include "fwekg_defs.vh"
module fwekg_checker (
  input wire i_clk,
  input wire i_rst_n,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [7:0] o_reg_rdata,
  input wire i_xw_req,
  input wire o_dm_wr,
  input wire o_fl_prog,
  input wire o_fl_erase,
  input wire [7:0] o_fl_data,
  input wire i_fl_done,
  input wire o_fl_busy,
  input wire o_trapped
);
  logic [1:0] psc_ff;
  wire key_wr = i_reg_wr && i_reg_addr == `FWEKG_ADDR_KEY;
  // Shadow of the control enables
  always @(posedge i_clk)
    if (!i_rst_n) psc_ff <= 2'b00;
    else if (i_reg_wr && i_reg_addr == `FWEKG_ADDR_PSC) psc_ff <= i_reg_wdata[1:0];
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_we_off_data: assert property (i_xw_req && !psc_ff[0] |=>
    o_dm_wr && !o_fl_prog && !o_fl_erase) else $error("flash touched");
  a_prog_cause: assert property (o_fl_prog |-> $past(i_xw_req) && $past(psc_ff) == 2'b01)
    else $error("bad program");
  a_erase_cause: assert property (o_fl_erase |-> $past(i_xw_req) &&
    $past(psc_ff) == 2'b11 && o_fl_data == 8'h00) else $error("bad erase");
  a_op_not_busy: assert property (o_fl_prog || o_fl_erase |-> !$past(o_fl_busy))
    else $error("op while busy");
  a_trap_sticky: assert property (o_trapped |=> o_trapped) else $error("trap left");
  a_bad_key: assert property (key_wr && i_reg_wdata != `FWEKG_KEY1 &&
    i_reg_wdata != `FWEKG_KEY2 |=> o_trapped) else $error("no trap");
  a_locked_try: assert property (i_xw_req && psc_ff[0] && o_trapped |=>
    !o_fl_prog && !o_fl_erase) else $error("op while trapped");
  a_psc_read: assert property (i_reg_rd && i_reg_addr == `FWEKG_ADDR_PSC |=>
    o_reg_rdata == {6'h00, $past(psc_ff)}) else $error("control read");
  a_dead_read: assert property (i_reg_rd && i_reg_addr == `FWEKG_ADDR_KEY && o_trapped
    |=> o_reg_rdata == 8'h03) else $error("key read");
  a_relock_busy: assert property (i_fl_done && o_fl_busy |=> !o_fl_busy)
    else $error("busy held");
endmodule
bind fwekg_guard fwekg_checker chk_i (.i_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata,
  .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_xw_req, .o_dm_wr, .o_fl_prog, .o_fl_erase,
  .o_fl_data, .i_fl_done, .o_fl_busy, .o_trapped);
`default_nettype wire

// >>> test_fwekg_guard.sv
/* Bench for the flash key guard: drives the ports, queues expectations.
   Assumes fwekg_guard and its checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
`include "fwekg_defs.vh"
module test_fwekg_guard;
  localparam logic [7:0] pa = `FWEKG_ADDR_PSC, ka = `FWEKG_ADDR_KEY, sa = `FWEKG_ADDR_IRQ_STAT;
  logic i_clk = 0, i_rst_n = 0, wr = 0, rd = 0, xr = 0, done = 0, rd_d = 0, xr_d = 0;
  logic [7:0] a = 0, d = 0, xd = 0, r, rdata, fd, dmd;
  logic [15:0] xa = 0, fa, dma, ea;
  logic dmw, fp, fe, busy, trp, irq;
  logic [7:0] qr[$];
  logic [7:0] qd[$];
  logic [15:0] qa[$];
  logic [2:0] qx[$];
  logic [2:0] ex;
  int mismatches = 0, comparisons = 0;
  // Clock at 200 MHz
  always #2.5 i_clk = ~i_clk;
  fwekg_guard uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_addr(a), .i_reg_wdata(d),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_xw_req(xr), .i_xw_addr(xa),
    .i_xw_data(xd), .o_dm_wr(dmw), .o_dm_addr(dma), .o_dm_data(dmd), .o_fl_prog(fp),
    .o_fl_erase(fe), .o_fl_addr(fa), .o_fl_data(fd), .i_fl_done(done), .o_fl_busy(busy),
    .o_trapped(trp), .o_irq(irq));
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task wrr(input logic [7:0] ad, input logic [7:0] v);
    @(posedge i_clk);
    a <= ad; d <= v; wr <= 1;
    @(posedge i_clk);
    wr <= 0;
  endtask
  task rdr(input logic [7:0] ad, input logic [7:0] e);
    @(posedge i_clk);
    a <= ad; rd <= 1; qr.push_back(e);
    @(posedge i_clk);
    rd <= 0;
  endtask
  task xw(input logic [2:0] e);
    logic [15:0] ta;
    logic [7:0] td;
    ta = 16'($urandom);
    td = 8'($urandom);
    @(posedge i_clk);
    xa <= ta;
    xd <= td;
    xr <= 1;
    qx.push_back(e);
    // Erase carries no data byte; a blocked try produces no write at all
    if (e != 3'b000) begin
      qa.push_back(ta);
      qd.push_back(e[0] ? 8'h00 : td);
    end
    @(posedge i_clk);
    xr <= 0;
  endtask
  // Finish a flash operation, then the guard must be locked again
  task fin;
    repeat (3) @(posedge i_clk);
    done <= 1;
    @(posedge i_clk);
    done <= 0;
    rdr(ka, 8'h00);
  endtask
  task rst;
    @(posedge i_clk);
    i_rst_n <= 0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1;
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Compare the oldest note when a result stands
  always @(posedge i_clk) begin
    rd_d <= rd;
    xr_d <= xr;
    if (rd_d) chk("rdata", rdata, qr.pop_front());
    if (xr_d) begin
      ex = qx.pop_front();
      chk("xw", {5'h0, dmw, fp, fe}, {5'h0, ex});
      if (ex != 3'b000) begin
        ea = qa.pop_front();
        chk("addr_lo", ex[2] ? dma[7:0] : fa[7:0], ea[7:0]);
        chk("addr_hi", ex[2] ? dma[15:8] : fa[15:8], ea[15:8]);
        chk("wdata", ex[2] ? dmd : fd, qd.pop_front());
      end
    end
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    conclude;
  end
  initial begin
    void'($urandom(32'h7b2abd1a));
    r = 8'($urandom);
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1;
    rdr(ka, 8'h00);
    wrr(pa, {r[7:2], 2'b10});
    rdr(pa, 8'h02);
    xw(3'b100);
    wrr(`FWEKG_ADDR_IRQ_EN, 8'h03);
    wrr(ka, `FWEKG_KEY1);
    rdr(ka, 8'h01);
    wrr(ka, `FWEKG_KEY2);
    rdr(ka, 8'h02);
    wrr(pa, {r[7:2], 2'b11});
    xw(3'b001);
    fin;
    rdr(sa, 8'h01);
    wrr(`FWEKG_ADDR_IRQ_CLR, 8'h01);
    rdr(sa, 8'h00);
    wrr(ka, `FWEKG_KEY1);
    wrr(ka, `FWEKG_KEY2);
    wrr(pa, 8'h01);
    xw(3'b010);
    fin;
    wrr(pa, 8'h01);
    xw(3'b000);
    rdr(ka, 8'h03);
    rdr(sa, 8'h03);
    @(negedge i_clk);
    chk("irq", {7'h0, irq}, 8'h01);
    wrr(`FWEKG_ADDR_IRQ_EN, 8'h00);
    @(negedge i_clk);
    chk("irq", {7'h0, irq}, 8'h00);
    wrr(ka, `FWEKG_KEY1);
    rdr(ka, 8'h03);
    rst;
    rdr(ka, 8'h00);
    wrr(ka, 8'h5a);
    rdr(ka, 8'h03);
    rst;
    wrr(ka, `FWEKG_KEY1);
    wrr(ka, 8'h00);
    rdr(ka, 8'h03);
    conclude;
  end
endmodule
`default_nettype wire
